// ### hw/maae_core.sv
// Accumulator arithmetic datapath: executes one opcode at a time, holds the
// accumulator, second operand register, status word and 16-bit data pointer.
// Assumes the decoder presents the external operand byte in the last cycle of the instruction.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// RL1: One instruction cycle per clock; cycle counts equal clock periods occupied.
// RL2: Fetch overlaps execution; one-cycle ops may follow back to back.
// RL3: ADD working register to accumulator, no carry in, one cycle.
// RL4: ADD direct byte to accumulator, no carry in, two cycles.
// RL5: ADD pointer-addressed byte to accumulator, no carry in, two cycles.
// RL6: ADD immediate byte to accumulator, no carry in, two cycles.
// RL7: ADD working register plus carry to accumulator, one cycle.
// RL8: Add with carry from direct, indirect or immediate operand, two cycles.
// RL9: Subtract working register and borrow from accumulator, one cycle.
// RL10: Subtract with borrow from direct, indirect or immediate operand, two cycles.
// RL11: Accumulator increment/decrement one cycle; working register forms two cycles.
// RL12: Direct or indirect increment three cycles; data pointer increment one cycle.
// RL13: Direct or indirect decrement three cycles.
// RL14: Multiply and divide accumulator by second register, five cycles each.
// RL15: Decimal adjust accumulator to packed BCD after addition, one cycle.
// RL16: All arithmetic is unsigned.
// RL17: Rotates, swap, clear, complement and decimal adjust act on accumulator only.
// RL18: Operands from accumulator, second register or outside; results to accumulator or out.
// RL19: Carry, overflow and parity are held in the readable status word.
// RL20: Every opcode gives the legacy core's architectural results.
// RL21: Bitwise AND, OR, exclusive OR and complement are provided.
// RL22: Divide by zero sets overflow; add and subtract update carry, half carry, overflow.
// RL23: Parity always shows even parity of the accumulator.
module maae_core (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_operand,
  input wire logic i_sfr_wr,
  input wire logic [maae_pkg::SFR_SEL_W-1:0] i_sfr_sel,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_data_pointer_16_wr,
  input wire logic [15:0] i_data_pointer_16_wdata,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_acc,
  output logic [7:0] o_b,
  output logic [7:0] o_psw,
  output logic [15:0] o_data_pointer_16,
  output logic [7:0] o_result,
  output logic o_result_valid
);
  import maae_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  // Maps an opcode to its operation class; unlisted opcodes are ignored.
  function automatic maae_cls_t cls_of(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    logic src;
    hi = op[7:4];
    lo = op[3:0];
    src = op[3] || (lo == FRM_IMM) || (lo == FRM_DIR) || (lo == FRM_IND0) || (lo == FRM_IND1);
    cls_of = CLS_NONE;
    if (op == OPC_INC_DATA_POINTER_16) cls_of = CLS_INCDP;
    else if (op == OPC_MUL) cls_of = CLS_MUL;
    else if (op == OPC_DIV) cls_of = CLS_DIV;
    else if (op == OPC_DA) cls_of = CLS_DA;
    else if (op == OPC_CLR) cls_of = CLS_CLR;
    else if (op == OPC_CPL) cls_of = CLS_CPL;
    else if (op == OPC_SWAP) cls_of = CLS_SWAP;
    else if (lo == FRM_ROT && hi == GRP_INC) cls_of = CLS_RR;
    else if (lo == FRM_ROT && hi == GRP_DEC) cls_of = CLS_RRC;
    else if (lo == FRM_ROT && hi == GRP_ADD) cls_of = CLS_RL;
    else if (lo == FRM_ROT && hi == GRP_ADDC) cls_of = CLS_RLC;
    else if (hi == GRP_INC && lo == FRM_IMM) cls_of = CLS_INCA;
    else if (hi == GRP_DEC && lo == FRM_IMM) cls_of = CLS_DECA;
    else if (hi == GRP_INC && src) cls_of = CLS_INCX;
    else if (hi == GRP_DEC && src) cls_of = CLS_DECX;
    else if (hi == GRP_ADD && src) cls_of = CLS_ADD;
    else if (hi == GRP_ADDC && src) cls_of = CLS_ADDC;
    else if (hi == GRP_SUBB && src) cls_of = CLS_SUBB;
    else if (hi == GRP_ANL && src) cls_of = CLS_ANL;
    else if (hi == GRP_ORL && src) cls_of = CLS_ORL;
    else if (hi == GRP_XRL && src) cls_of = CLS_XRL;
    else if (hi == GRP_ANL && lo == FRM_TO_DIR) cls_of = CLS_ANLX;
    else if (hi == GRP_ORL && lo == FRM_TO_DIR) cls_of = CLS_ORLX;
    else if (hi == GRP_XRL && lo == FRM_TO_DIR) cls_of = CLS_XRLX;
  endfunction : cls_of

  // Clock count of each instruction.
  function automatic logic [2:0] cyc_of(input maae_cls_t cls, input logic [7:0] op);
    cyc_of = CYC_1;
    unique case (cls)
      CLS_MUL, CLS_DIV: cyc_of = CYC_5; // see RL14
      CLS_INCX, CLS_DECX: cyc_of = op[3] ? CYC_2 : CYC_3; // see RL11 see RL12 see RL13
      CLS_ANLX, CLS_ORLX, CLS_XRLX: cyc_of = CYC_3;
      CLS_ADD, CLS_ADDC, CLS_SUBB, CLS_ANL, CLS_ORL, CLS_XRL: cyc_of = op[3] ? CYC_1 : CYC_2; // see RL4 see RL5 see RL6 see RL8 see RL10
      CLS_NONE, CLS_INCA, CLS_DECA, CLS_INCDP, CLS_DA, CLS_CLR, CLS_CPL, CLS_RL, CLS_RLC,
      CLS_RR, CLS_RRC, CLS_SWAP: cyc_of = CYC_1;
    endcase
  endfunction : cyc_of

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  maae_cls_t cls_in;
  maae_cls_t cls_reg;
  maae_cls_t cls_cur;
  logic [2:0] cyc_in;
  logic [2:0] cnt_reg;
  logic busy_reg;
  logic ready_reg;
  logic accept;
  logic commit;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] b_reg, b_next;
  logic [7:0] psw_reg, psw_next;
  logic [15:0] data_pointer_16_reg, data_pointer_16_next;
  logic [7:0] res_reg, res_next;
  logic res_vld_reg;
  logic done_reg;
  logic md_start;
  logic [15:0] md_prod;
  logic [7:0] md_quot;
  logic [7:0] md_rem;
  logic md_zero;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing

  // An opcode is taken whenever the unit is ready; a one-cycle opcode commits at once.
  assign cls_in = cls_of(i_opcode); // see RL20
  assign cyc_in = cyc_of(cls_in, i_opcode);
  assign accept = i_op_valid && ready_reg;
  assign commit = (accept && cyc_in == CYC_1) || (busy_reg && cnt_reg == 3'h1); // see RL1
  assign cls_cur = busy_reg ? cls_reg : cls_in;
  assign md_start = accept && (cls_in == CLS_MUL || cls_in == CLS_DIV);

  // Counts the remaining clocks of a multi-cycle opcode; ready stays high for one-cycle ones.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      ready_reg <= 1'b1;
      cnt_reg <= 3'h0;
      cls_reg <= CLS_NONE;
    end else if (accept && cyc_in != CYC_1) begin
      busy_reg <= 1'b1; // see RL1
      ready_reg <= 1'b0;
      cnt_reg <= cyc_in - 3'h1;
      cls_reg <= cls_in;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1) begin
        busy_reg <= 1'b0; // see RL2
        ready_reg <= 1'b1;
      end
    end
  end

  // Multiply and divide work on the accumulator and second register seen at the start.
  maae_muldiv u_muldiv (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(md_start),
    .i_a(acc_reg),
    .i_b(b_reg),
    .o_prod(md_prod),
    .o_quot(md_quot),
    .o_rem(md_rem),
    .o_div_zero(md_zero)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath

  // Computes next values of accumulator, B, status word, data pointer and result; a committing opcode wins over a core register write.
  always_comb begin
    logic cin;
    logic cy;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [8:0] dif9;
    logic [4:0] dnib5;
    logic [8:0] da1;
    logic [8:0] da2;
    logic da_c;
    cy = psw_reg[PSW_CY];
    cin = (cls_cur == CLS_ADDC) ? cy : 1'b0; // see RL3 see RL7
    sum9 = {1'b0, acc_reg} + {1'b0, i_operand} + {8'h00, cin}; // see RL16
    nib5 = {1'b0, acc_reg[3:0]} + {1'b0, i_operand[3:0]} + {4'h0, cin};
    dif9 = {1'b0, acc_reg} - {1'b0, i_operand} - {8'h00, cy};
    dnib5 = {1'b0, acc_reg[3:0]} - {1'b0, i_operand[3:0]} - {4'h0, cy};
    da1 = {1'b0, acc_reg};
    if (acc_reg[3:0] > BCD_DIGIT_MAX || psw_reg[PSW_AC]) begin
      da1 = da1 + DA_ADJ_LO;
    end
    da_c = cy | da1[8];
    da2 = {1'b0, da1[7:0]};
    if (da1[7:4] > BCD_DIGIT_MAX || da_c) begin
      da2 = da2 + DA_ADJ_HI;
    end
    da_c = da_c | da2[8];
    acc_next = acc_reg;
    b_next = b_reg;
    psw_next = psw_reg;
    data_pointer_16_next = data_pointer_16_reg;
    res_next = res_reg;
    if (commit) begin
      unique case (cls_cur)
        CLS_ADD, CLS_ADDC: begin
          acc_next = sum9[7:0]; // see RL3 see RL4 see RL5 see RL6 see RL7 see RL8
          psw_next[PSW_CY] = sum9[8]; // see RL22
          psw_next[PSW_AC] = nib5[4];
          psw_next[PSW_OV] = (acc_reg[7] == i_operand[7]) && (sum9[7] != acc_reg[7]);
        end
        CLS_SUBB: begin
          acc_next = dif9[7:0]; // see RL9 see RL10
          psw_next[PSW_CY] = dif9[8]; // see RL22
          psw_next[PSW_AC] = dnib5[4];
          psw_next[PSW_OV] = (acc_reg[7] != i_operand[7]) && (dif9[7] != acc_reg[7]);
        end
        CLS_INCA: acc_next = acc_reg + 8'h01; // see RL11
        CLS_DECA: acc_next = acc_reg - 8'h01; // see RL11
        CLS_INCX: res_next = i_operand + 8'h01; // see RL11 see RL12 see RL18
        CLS_DECX: res_next = i_operand - 8'h01; // see RL11 see RL13 see RL18
        CLS_INCDP: data_pointer_16_next = data_pointer_16_reg + 16'h0001; // see RL12
        CLS_MUL: begin
          acc_next = md_prod[7:0]; // see RL14 see RL16
          b_next = md_prod[15:8];
          psw_next[PSW_CY] = 1'b0;
          psw_next[PSW_OV] = (md_prod[15:8] != 8'h00);
        end
        CLS_DIV: begin
          psw_next[PSW_CY] = 1'b0;
          psw_next[PSW_OV] = md_zero; // see RL22
          if (!md_zero) begin
            acc_next = md_quot; // see RL14
            b_next = md_rem;
          end
        end
        CLS_DA: begin
          acc_next = da2[7:0]; // see RL15 see RL17
          psw_next[PSW_CY] = da_c;
        end
        CLS_ANL: acc_next = acc_reg & i_operand; // see RL21
        CLS_ORL: acc_next = acc_reg | i_operand; // see RL21
        CLS_XRL: acc_next = acc_reg ^ i_operand; // see RL21
        CLS_ANLX: res_next = acc_reg & i_operand; // see RL18
        CLS_ORLX: res_next = acc_reg | i_operand;
        CLS_XRLX: res_next = acc_reg ^ i_operand;
        CLS_CLR: acc_next = 8'h00; // see RL17
        CLS_CPL: acc_next = ~acc_reg; // see RL17 see RL21
        CLS_RL: acc_next = {acc_reg[6:0], acc_reg[7]}; // see RL17
        CLS_RLC: begin
          acc_next = {acc_reg[6:0], cy}; // see RL17
          psw_next[PSW_CY] = acc_reg[7];
        end
        CLS_RR: acc_next = {acc_reg[0], acc_reg[7:1]}; // see RL17
        CLS_RRC: begin
          acc_next = {cy, acc_reg[7:1]}; // see RL17
          psw_next[PSW_CY] = acc_reg[0];
        end
        CLS_SWAP: acc_next = {acc_reg[3:0], acc_reg[7:4]}; // see RL17
        CLS_NONE: begin
        end
      endcase
    end else if (i_sfr_wr) begin
      case (i_sfr_sel)
        SFR_ACC: acc_next = i_sfr_wdata;
        SFR_B: b_next = i_sfr_wdata;
        SFR_PSW: psw_next = i_sfr_wdata; // see RL19
        default: begin
        end
      endcase
    end
    if (!commit && i_data_pointer_16_wr) begin
      data_pointer_16_next = i_data_pointer_16_wdata;
    end
    psw_next[PSW_P] = ^acc_next; // see RL23
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers

  // Accumulator and second operand register.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      acc_reg <= ACC_RST;
      b_reg <= B_RST;
    end else begin
      acc_reg <= acc_next; // see RL18
      b_reg <= b_next;
    end
  end

  // Status word with live parity, and the data pointer.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      psw_reg <= PSW_RST;
      data_pointer_16_reg <= DATA_POINTER_16_RST;
    end else begin
      psw_reg <= psw_next; // see RL19
      data_pointer_16_reg <= data_pointer_16_next;
    end
  end

  // Result driven out of the unit and the completion pulses.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      res_reg <= 8'h00;
      res_vld_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      res_vld_reg <= commit && (cls_cur == CLS_INCX || cls_cur == CLS_DECX || cls_cur == CLS_ANLX ||
                                cls_cur == CLS_ORLX || cls_cur == CLS_XRLX); // see RL18
      done_reg <= commit; // see RL1
    end
  end

  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_acc = acc_reg;
  assign o_b = b_reg;
  assign o_psw = psw_reg;
  assign o_data_pointer_16 = data_pointer_16_reg;
  assign o_result = res_reg;
  assign o_result_valid = res_vld_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_two_cycle;
    !o_done ##1 o_done;
  endsequence
  sequence s_three_cycle;
    !o_done [*2] ##1 o_done;
  endsequence
  sequence s_five_cycle;
    !o_ready [*4] ##1 (o_done && o_ready);
  endsequence

  a_one_cycle_done: assert property (accept && cyc_in == CYC_1 |=> o_done && o_ready) // see RL2
    else $error("one-cycle opcode did not finish in one clock");
  a_direct_add_time: assert property (accept && i_opcode == {GRP_ADD, FRM_DIR} |=> s_two_cycle) // see RL4
    else $error("direct add did not take two clocks");
  a_inc_dir_time: assert property (accept && i_opcode == {GRP_INC, FRM_DIR} |=> s_three_cycle) // see RL12
    else $error("direct increment did not take three clocks");
  a_muldiv_time: assert property (accept && (i_opcode == OPC_MUL || i_opcode == OPC_DIV) |=> s_five_cycle) // see RL14
    else $error("multiply or divide did not take five clocks");
  a_add_reg_sum: assert property (accept && i_opcode[7:3] == {GRP_ADD, 1'b1}
                                  |=> o_acc == 8'($past(o_acc) + $past(i_operand))) // see RL3
    else $error("register add gave a wrong sum");
  a_addc_reg_sum: assert property (accept && i_opcode[7:3] == {GRP_ADDC, 1'b1}
                                   |=> o_acc == 8'($past(o_acc) + $past(i_operand) + $past(o_psw[PSW_CY]))) // see RL7
    else $error("register add with carry gave a wrong sum");
  a_subb_reg_diff: assert property (accept && i_opcode[7:3] == {GRP_SUBB, 1'b1}
                                    |=> o_acc == 8'($past(o_acc) - $past(i_operand) - $past(o_psw[PSW_CY]))) // see RL9
    else $error("register subtract with borrow gave a wrong difference");
  a_parity_live: assert property (o_psw[PSW_P] == ^o_acc) // see RL23
    else $error("parity flag does not match accumulator");
  a_div_zero_ov: assert property (accept && i_opcode == OPC_DIV && o_b == 8'h00 |-> ##5 o_psw[PSW_OV]) // see RL22
    else $error("divide by zero did not set overflow");
  a_mul_product: assert property (accept && i_opcode == OPC_MUL
                                  |-> ##5 {o_b, o_acc} == 16'($past(o_acc, 5) * $past(o_b, 5))) // see RL16
    else $error("unsigned product is wrong");
  a_swap_nibbles: assert property (accept && i_opcode == OPC_SWAP |=> o_acc == {$past(o_acc[3:0]), $past(o_acc[7:4])}) // see RL17
    else $error("nibble swap is wrong");
  a_data_pointer_16_step: assert property (accept && i_opcode == OPC_INC_DATA_POINTER_16 |=> o_data_pointer_16 == 16'($past(o_data_pointer_16) + 16'h0001)) // see RL12
    else $error("data pointer increment is wrong");

endmodule : maae_core
`default_nettype wire

// ### hw/maae_muldiv.sv
// Eight-bit unsigned multiply and divide stage of the datapath.
// Assumes operands are stable at the start strobe; results are held until the next start.
`timescale 1ns/1ps
`default_nettype none
module maae_muldiv (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  output logic [15:0] o_prod,
  output logic [7:0] o_quot,
  output logic [7:0] o_rem,
  output logic o_div_zero
);
  import maae_pkg::*;

  // Capture the product once per start, and quotient and remainder only for a nonzero divisor; a zero divisor is flagged.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prod <= 16'h0000;
      o_quot <= 8'h00;
      o_rem <= 8'h00;
      o_div_zero <= 1'b0;
    end else if (i_start) begin
      o_prod <= {8'h00, i_a} * {8'h00, i_b};
      o_div_zero <= (i_b == 8'h00);
      if (i_b != 8'h00) begin
        o_quot <= i_a / i_b;
        o_rem <= i_a % i_b;
      end
    end
  end

endmodule : maae_muldiv
`default_nettype wire

// ### hw/maae_pkg.sv
// Package of the accumulator arithmetic datapath: opcode fields, cycle counts,
// status word bit positions, reset values and the operation classes.
// Assumes a decoder that hands over one whole opcode per instruction.
package maae_pkg;

  // Opcode groups, taken from the high nibble of the opcode.
  localparam logic [3:0] GRP_INC = 4'h0, GRP_DEC = 4'h1, GRP_ADD = 4'h2, GRP_ADDC = 4'h3;
  localparam logic [3:0] GRP_ORL = 4'h4, GRP_ANL = 4'h5, GRP_XRL = 4'h6, GRP_SUBB = 4'h9;

  // Operand forms, taken from the low nibble; bit 3 set means a working register.
  localparam logic [3:0] FRM_TO_DIR = 4'h2, FRM_ROT = 4'h3, FRM_IMM = 4'h4, FRM_DIR = 4'h5;
  localparam logic [3:0] FRM_IND0 = 4'h6, FRM_IND1 = 4'h7;

  // Single opcodes.
  localparam logic [7:0] OPC_INC_DATA_POINTER_16 = 8'hA3, OPC_MUL = 8'hA4, OPC_DIV = 8'h84, OPC_DA = 8'hD4;
  localparam logic [7:0] OPC_CLR = 8'hE4, OPC_CPL = 8'hF4, OPC_SWAP = 8'hC4;

  // Instruction lengths in core clocks.
  localparam logic [2:0] CYC_1 = 3'h1, CYC_2 = 3'h2, CYC_3 = 3'h3, CYC_5 = 3'h5;

  // Status word bit positions.
  localparam int PSW_CY = 7, PSW_AC = 6, PSW_OV = 2, PSW_P = 0;

  // Reset values.
  localparam logic [7:0] ACC_RST = 8'h00, B_RST = 8'h00, PSW_RST = 8'h00;
  localparam logic [15:0] DATA_POINTER_16_RST = 16'h0000;

  // Special function register select codes for core writes.
  localparam int SFR_SEL_W = 2;
  localparam logic [1:0] SFR_ACC = 2'h0, SFR_B = 2'h1, SFR_PSW = 2'h2;

  // Decimal adjust constants.
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [8:0] DA_ADJ_LO = 9'h006, DA_ADJ_HI = 9'h060;

  // Operation classes; the X forms drive their result out of the unit.
  typedef enum logic [4:0] {
    CLS_NONE, CLS_ADD, CLS_ADDC, CLS_SUBB, CLS_INCA, CLS_DECA, CLS_INCX, CLS_DECX,
    CLS_INCDP, CLS_MUL, CLS_DIV, CLS_DA, CLS_ANL, CLS_ORL, CLS_XRL, CLS_ANLX,
    CLS_ORLX, CLS_XRLX, CLS_CLR, CLS_CPL, CLS_RL, CLS_RLC, CLS_RR, CLS_RRC, CLS_SWAP
  } maae_cls_t;

endpackage : maae_pkg

// ### verif/maae_core_tb_top.sv
// Self-checking bench of the accumulator datapath against a behavioural model.
// Assumes the package and the decoder model are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module maae_core_tb_top;
  import maae_pkg::*;
  logic i_sys_clk, i_rst, i_sfr_wr, i_data_pointer_16_wr, o_ready, o_done, o_result_valid, op_valid, m_rv;
  logic [SFR_SEL_W-1:0] i_sfr_sel;
  logic [7:0] i_sfr_wdata, o_acc, o_b, o_psw, o_result, opcode, operand, m_acc, m_b, m_psw, m_res;
  logic [15:0] i_data_pointer_16_wdata, o_data_pointer_16, m_data_pointer_16;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] ops [48] = '{8'h2B, 8'h25, 8'h26, 8'h27, 8'h24, 8'h3A, 8'h35, 8'h36, 8'h37, 8'h34, 8'h9D, 8'h95,
    8'h96, 8'h97, 8'h94, 8'h04, 8'h14, 8'h0C, 8'h1E, 8'h05, 8'h06, 8'h07, 8'h15, 8'h16, 8'h17, 8'hA3, 8'hA4, 8'h84,
    8'hD4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hE4, 8'hF4, 8'h59, 8'h55, 8'h54, 8'h52, 8'h4B, 8'h45, 8'h42, 8'h6F,
    8'h64, 8'h62, 8'h65, 8'h00};

  maae_core i_maae_core (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_op_valid(op_valid), .i_opcode(opcode),
    .i_operand(operand), .i_sfr_wr(i_sfr_wr), .i_sfr_sel(i_sfr_sel), .i_sfr_wdata(i_sfr_wdata),
    .i_data_pointer_16_wr(i_data_pointer_16_wr), .i_data_pointer_16_wdata(i_data_pointer_16_wdata), .o_ready(o_ready), .o_done(o_done), .o_acc(o_acc),
    .o_b(o_b), .o_psw(o_psw), .o_data_pointer_16(o_data_pointer_16), .o_result(o_result), .o_result_valid(o_result_valid));
  maae_decoder_model i_maae_decoder_model (.i_sys_clk(i_sys_clk), .i_ready(o_ready), .i_done(o_done),
    .o_op_valid(op_valid), .o_opcode(opcode), .o_operand(operand));

  // Free-running 50 ns clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ends the run with the verdict.
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Reference model of one opcode; returns its clock count.
  task automatic model(input logic [7:0] op, input logic [7:0] x, output int n);
    int t, c;
    logic cy, ac, ov;
    logic [3:0] hi, lo;
    hi = op[7:4];
    lo = op[3:0];
    {cy, ac, ov} = {m_psw[7], m_psw[6], m_psw[2]};
    m_rv = 1'b0;
    if (op == OPC_MUL || op == OPC_DIV) n = 5;
    else if ((hi <= 1 && lo inside {[5:7]}) || lo == 2) n = 3;
    else if (hi <= 1 ? lo >= 8 : (lo inside {[4:7]} && hi inside {2, 3, 4, 5, 6, 9})) n = 2;
    else n = 1;
    if (hi inside {2, 3, 9} && lo >= 4) begin
      c = (hi == 2) ? 0 : cy;
      t = (hi == 9) ? m_acc - x - c : m_acc + x + c;
      ac = (hi == 9) ? (m_acc[3:0] < x[3:0] + c) : (m_acc[3:0] + x[3:0] + c > 15);
      ov = (t[7] != m_acc[7]) && ((m_acc[7] == x[7]) == (hi != 9));
      cy = (t < 0) || (t > 255);
      m_acc = t[7:0];
    end else if (hi inside {2, 3} && lo == 3) begin
      t = m_acc[7];
      m_acc = {m_acc[6:0], (hi == 3) ? cy : m_acc[7]};
      if (hi == 3) cy = t[0];
    end else if (hi inside {4, 5, 6} && lo != 3) begin
      t = (hi == 4) ? (m_acc | x) : (hi == 5) ? (m_acc & x) : (m_acc ^ x);
      if (lo == 2) begin
        m_res = t[7:0];
        m_rv = 1'b1;
      end else m_acc = t[7:0];
    end else if (hi <= 1) begin
      t = (hi == 0) ? 1 : -1;
      if (lo == 4) m_acc = m_acc + t[7:0];
      else if (lo == 3) begin
        c = m_acc[0];
        m_acc = {(hi == 1) ? cy : m_acc[0], m_acc[7:1]};
        if (hi == 1) cy = c[0];
      end else if (lo >= 5) begin
        m_res = x + t[7:0];
        m_rv = 1'b1;
      end
    end else case (op)
      OPC_INC_DATA_POINTER_16: m_data_pointer_16 = m_data_pointer_16 + 16'h0001;
      OPC_MUL: begin
        t = m_acc * m_b;
        {m_b, m_acc} = t[15:0];
        {cy, ov} = {1'b0, t > 255};
      end
      OPC_DIV: begin
        {cy, ov} = {1'b0, m_b == 0};
        if (m_b != 0) begin
          t = m_acc / m_b;
          m_b = m_acc % m_b;
          m_acc = t[7:0];
        end
      end
      OPC_DA: begin
        t = m_acc;
        if (t % 16 > 9 || ac) t = t + 6;
        if (t > 255) cy = 1'b1;
        t = t % 256;
        if (t / 16 > 9 || cy) t = t + 96;
        if (t > 255) cy = 1'b1;
        m_acc = t[7:0];
      end
      OPC_SWAP: m_acc = {m_acc[3:0], m_acc[7:4]};
      OPC_CLR: m_acc = 8'h00;
      OPC_CPL: m_acc = ~m_acc;
      default: n = 1;
    endcase
    m_psw = {cy, ac, m_psw[5:3], ov, m_psw[1], ^m_acc};
  endtask : model

  // Runs one opcode through the decoder model and compares every visible register.
  task automatic run(input logic [7:0] op, input logic [7:0] x);
    int n;
    model(op, x, n);
    i_maae_decoder_model.issue(op, x, n);
    chk("done", 16'h0001, {15'h0000, o_done});
    chk("ready", 16'h0001, {15'h0000, o_ready});
    chk("busy", 16'h0000, {15'h0000, i_maae_decoder_model.busy_bad});
    chk("result_valid", {15'h0000, m_rv}, {15'h0000, o_result_valid});
    chk("acc", {8'h00, m_acc}, {8'h00, o_acc});
    chk("b", {8'h00, m_b}, {8'h00, o_b});
    chk("psw", {8'h00, m_psw}, {8'h00, o_psw});
    chk("data_pointer_16", m_data_pointer_16, o_data_pointer_16);
    chk("result", {8'h00, m_res}, {8'h00, o_result});
  endtask : run

  // Writes one core register between instructions and mirrors it in the model.
  task automatic sfr(input logic [SFR_SEL_W-1:0] sel, input logic [7:0] d);
    {i_sfr_wr, i_sfr_sel, i_sfr_wdata} = {1'b1, sel, d};
    @(posedge i_sys_clk);
    #2;
    i_sfr_wr = 1'b0;
    @(posedge i_sys_clk);
    #2;
    if (sel == SFR_ACC) m_acc = d;
    if (sel == SFR_B) m_b = d;
    if (sel == SFR_PSW) m_psw = d;
    m_psw[0] = ^m_acc;
  endtask : sfr

  // Main sequence: reset, every opcode in ops back to back, corner cases, then random traffic.
  initial begin
    logic [7:0] op;
    void'($urandom(32'h10b976b8));
    {i_rst, i_sfr_wr, i_sfr_sel, i_sfr_wdata, i_data_pointer_16_wr, i_data_pointer_16_wdata} = '0;
    i_rst = 1'b1;
    {m_acc, m_b, m_psw, m_res, m_data_pointer_16, m_rv} = '0;
    repeat (12) @(posedge i_sys_clk);
    #2;
    i_rst = 1'b0;
    run(8'h00, 8'h00);
    for (int i = 0; i < 48; i++) run(ops[i], 8'($urandom));
    i_maae_decoder_model.idle();
    sfr(SFR_B, 8'h00);
    run(OPC_DIV, 8'h00);
    i_maae_decoder_model.idle();
    {i_data_pointer_16_wr, i_data_pointer_16_wdata} = {1'b1, 16'hFFFF};
    @(posedge i_sys_clk);
    #2;
    i_data_pointer_16_wr = 1'b0;
    m_data_pointer_16 = 16'hFFFF;
    run(OPC_INC_DATA_POINTER_16, 8'h00);
    {i_sfr_wr, i_sfr_sel, i_sfr_wdata} = {1'b1, SFR_ACC, 8'h5A};
    run(OPC_CPL, 8'h00);
    i_sfr_wr = 1'b0;
    for (int k = 0; k < 600; k++) begin
      op = ops[$urandom_range(47, 0)];
      if (op[3]) op[2:0] = 3'($urandom);
      run(op, 8'($urandom));
      if ($urandom_range(3, 0) == 0) begin
        i_maae_decoder_model.idle();
        sfr(SFR_SEL_W'($urandom), 8'($urandom));
      end
    end
    i_maae_decoder_model.idle();
    print_verdict();
  end

  // Watchdog sized for about twenty thousand clocks, several times the expected run.
  initial begin
    #1000000;
    n_errors++;
    print_verdict();
  end
endmodule : maae_core_tb_top
`default_nettype wire

// ### verif/maae_decoder_model.sv
// Decoder-side model that offers opcodes to the datapath and feeds operand bytes.
// Assumes the bench calls issue just after a rising edge while the datapath is ready.
`timescale 1ns/1ps
`default_nettype none
module maae_decoder_model (
  input wire logic i_sys_clk,
  input wire logic i_ready,
  input wire logic i_done,
  output logic o_op_valid,
  output logic [7:0] o_opcode,
  output logic [7:0] o_operand
);
  logic busy_bad;

  // Idle values at time zero.
  initial begin
    o_op_valid = 1'b0;
    o_opcode = 8'h00;
    o_operand = 8'h00;
    busy_bad = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Offers one opcode for n clocks; the operand byte is valid only in the commit cycle.
  // The opcode stays offered while busy, so a datapath that retakes it is caught.
  task automatic issue(input logic [7:0] op, input logic [7:0] opr, input int n);
    o_opcode = op;
    o_op_valid = 1'b1;
    o_operand = (n == 1) ? opr : ~o_operand;
    @(posedge i_sys_clk);
    #2;
    for (int i = 1; i < n; i++) begin
      if (i_ready !== 1'b0 || i_done !== 1'b0) busy_bad = 1'b1;
      o_operand = (i == n - 1) ? opr : ~o_operand;
      @(posedge i_sys_clk);
      #2;
    end
  endtask : issue

  // Withdraws the opcode; the operand byte keeps toggling since nothing qualifies it.
  task automatic idle();
    o_op_valid = 1'b0;
    o_operand = ~o_operand;
    @(posedge i_sys_clk);
    #2;
  endtask : idle
endmodule : maae_decoder_model
`default_nettype wire
